/* pkg/ssc_pkg.sv */
// constants, register map and field layout of the second stage config slice
package ssc_pkg;
  // register offsets on the plain port (index, no byte scaling)
  localparam logic [7:0] ADDR_PROBE = 8'h27;
  localparam logic [7:0] ADDR_SHIFT = 8'h28;
  localparam logic [7:0] ADDR_CUR1 = 8'h29;
  localparam logic [7:0] ADDR_TOPO = 8'h2A;
  // reset values
  localparam logic [7:0] RST_PROBE = 8'h00;
  localparam logic [7:0] RST_SHIFT = 8'h00;
  localparam logic [7:0] RST_CUR1 = 8'h00;
  localparam logic [7:0] RST_TOPO = 8'h00;
  // field positions
  localparam int PROBE_EN_BIT = 7;
  localparam int MEAS_HI = 6;
  localparam int MEAS_LO = 3;
  localparam logic [7:0] PROBE_MASK = 8'hF8;
  localparam int SHIFT_HI = 7;
  localparam int SHIFT_LO = 4;
  localparam int DLY_HI = 3;
  localparam int DLY_LO = 1;
  localparam int MSB_BIT = 0;
  localparam int TOPO_HI = 7;
  localparam int TOPO_LO = 4;
  // probe interval: cycles = 16 * count + 16
  localparam int PROBE_MULT = 16;
  localparam int PROBE_BASE = 16;
  // delay step in ns and clock period in ns
  localparam int DLY_STEP_NS = 50;
  localparam int CLK_PERIOD_NS = 8;
  // cycles per delay step, rounded up
  localparam int DLY_STEP_CYC =
    (DLY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INTEG_W = 24;
  localparam int THRESH_W = 10;
  localparam int CUR_W = 9;
  // topology encodings
  localparam logic [3:0] TOPO_NORMAL = 4'h0;
  localparam logic [3:0] TOPO_UNITY = 4'h1;
endpackage

/* hw/ssc_zcd_delay.sv */
// programmable edge delay for the zero-cross detect signal
`timescale 1ns/1ps
module ssc_zcd_delay #(
  parameter int STEP_CYC = ssc_pkg::DLY_STEP_CYC,
  parameter int CNT_W = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic zcd_in,
  input wire logic [2:0] rise_steps,
  input wire logic [2:0] fall_steps,
  output logic zcd_out
);
  logic out_r, out_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] target;

  // target count for the edge now pending
  always_comb begin
    if (zcd_in) begin
      target = CNT_W'(rise_steps * STEP_CYC);
    end else begin
      target = CNT_W'(fall_steps * STEP_CYC);
    end
  end

  // output follows input after the per-edge delay
  always_comb begin
    out_nxt = out_r;
    cnt_nxt = cnt_r;
    if (zcd_in == out_r) begin
      cnt_nxt = '0;
    end else if (cnt_r >= target) begin
      out_nxt = zcd_in;
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      out_r <= out_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign zcd_out = out_r;
endmodule // ssc_zcd_delay

/* hw/ssc_probe_timer.sv */
// counts switching cycles and pulses when a resonance probe is due
`timescale 1ns/1ps
module ssc_probe_timer #(
  parameter int CNT_W = 9 // longest interval is 256 ticks
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [3:0] interval,
  input wire logic cycle_tick,
  output logic probe_req
);
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic req_r, req_nxt;
  logic [CNT_W-1:0] limit;

  assign limit = CNT_W'(interval * ssc_pkg::PROBE_MULT
    + ssc_pkg::PROBE_BASE);

  // one request after every limit switching cycles
  always_comb begin
    cnt_nxt = cnt_r;
    req_nxt = 1'b0;
    if (!enable) begin
      cnt_nxt = '0;
    end else if (cycle_tick) begin
      if (cnt_r + 1'b1 >= limit) begin
        cnt_nxt = '0;
        req_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      req_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      req_r <= req_nxt;
    end
  end

  assign probe_req = req_r;
endmodule // ssc_probe_timer

/* hw/ssc_config_regs.sv */
// second stage configuration registers and the logic they steer
// Notes on behaviour
// - probe on: measure every 16*count+16 switching cycles, else never
// - threshold is 24-bit integrator shifted right by shift field, 10 bits
// - peak rectify: low bits left after the shift are the threshold
// - channel 1 falling detect delayed by field times 50 ns
// - channel 1 target is 9-bit unsigned, register plus extension bit
// - shift register bit 0 is bit 8 of channel 1 target
// - topology 0 normal, 1 unity tapped as normal, 2-15 tapped ratio
// - channel 1 rising detect delayed by field times 50 ns
// - topology register bit 0 is bit 8 of channel 2 target
// - channel 2 target is 9-bit, external byte plus extension bit
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module ssc_config_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [23:0] integrator,
  input wire logic [7:0] chan2_target_current,
  input wire logic switch_cycle_tick,
  input wire logic zero_cross_detect,
  input wire logic chan1_active,
  output logic [9:0] peak_threshold,
  output logic [8:0] chan1_target,
  output logic [8:0] chan2_target,
  output logic probe_request,
  output logic zcd_delayed,
  output logic tapped_buck,
  output logic [3:0] tap_ratio
);
  logic [7:0] probe_r, probe_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] cur1_r, cur1_nxt;
  logic [7:0] topo_r, topo_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [9:0] thr_r, thr_nxt;
  logic [8:0] t1_r, t1_nxt;
  logic [8:0] t2_r, t2_nxt;
  logic tap_r, tap_nxt;
  logic [3:0] ratio_r, ratio_nxt;
  logic zs1_r, zs2_r;
  logic [23:0] shifted;
  logic [3:0] topo_f;
  logic dly_out;
  logic zdl_r, zdl_nxt;

  // register writes; reserved probe bits masked off
  always_comb begin
    probe_nxt = probe_r;
    shift_nxt = shift_r;
    cur1_nxt = cur1_r;
    topo_nxt = topo_r;
    if (reg_wr) begin
      case (reg_addr)
        ssc_pkg::ADDR_PROBE: begin
          probe_nxt = reg_wdata & ssc_pkg::PROBE_MASK;
        end
        ssc_pkg::ADDR_SHIFT: begin
          shift_nxt = reg_wdata;
        end
        ssc_pkg::ADDR_CUR1: begin
          cur1_nxt = reg_wdata;
        end
        ssc_pkg::ADDR_TOPO: begin
          topo_nxt = reg_wdata;
        end
        default: begin
          probe_nxt = probe_r;
        end
      endcase
    end
  end

  // read data, valid the cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ssc_pkg::ADDR_PROBE: begin
          rdata_nxt = probe_r & ssc_pkg::PROBE_MASK;
        end
        ssc_pkg::ADDR_SHIFT: begin
          rdata_nxt = shift_r;
        end
        ssc_pkg::ADDR_CUR1: begin
          rdata_nxt = cur1_r;
        end
        ssc_pkg::ADDR_TOPO: begin
          rdata_nxt = topo_r;
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      probe_r <= ssc_pkg::RST_PROBE;
      shift_r <= ssc_pkg::RST_SHIFT;
      cur1_r <= ssc_pkg::RST_CUR1;
      topo_r <= ssc_pkg::RST_TOPO;
      rdata_r <= 8'h00;
    end else begin
      probe_r <= probe_nxt;
      shift_r <= shift_nxt;
      cur1_r <= cur1_nxt;
      topo_r <= topo_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // integrator shift and truncation to the comparator width
  assign shifted = integrator >> shift_r[ssc_pkg::SHIFT_HI:ssc_pkg::SHIFT_LO];
  assign topo_f = topo_r[ssc_pkg::TOPO_HI:ssc_pkg::TOPO_LO];

  // derived control outputs
  always_comb begin
    thr_nxt = shifted[ssc_pkg::THRESH_W-1:0];
    t1_nxt = {shift_r[ssc_pkg::MSB_BIT], cur1_r};
    t2_nxt = {topo_r[ssc_pkg::MSB_BIT],
      chan2_target_current};
    tap_nxt = 1'b0;
    ratio_nxt = topo_f;
    case (topo_f)
      ssc_pkg::TOPO_NORMAL: begin
        tap_nxt = 1'b0;
      end
      ssc_pkg::TOPO_UNITY: begin
        tap_nxt = 1'b0;
      end
      default: begin
        tap_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_r <= '0;
      t1_r <= '0;
      t2_r <= '0;
      tap_r <= 1'b0;
      ratio_r <= 4'h0;
    end else begin
      thr_r <= thr_nxt;
      t1_r <= t1_nxt;
      t2_r <= t2_nxt;
      tap_r <= tap_nxt;
      ratio_r <= ratio_nxt;
    end
  end

  assign peak_threshold = thr_r;
  assign chan1_target = t1_r;
  assign chan2_target = t2_r;
  assign tapped_buck = tap_r;
  assign tap_ratio = ratio_r;

  // two-stage synchroniser for the comparator pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zs1_r <= 1'b0;
      zs2_r <= 1'b0;
    end else begin
      zs1_r <= zero_cross_detect;
      zs2_r <= zs1_r;
    end
  end

  // periodic resonance probe scheduling
  ssc_probe_timer #(
    .CNT_W(9)
  ) u_probe (
    .clk(clk),
    .rst_n(rst_n),
    .enable(probe_r[ssc_pkg::PROBE_EN_BIT]),
    .interval(probe_r[ssc_pkg::MEAS_HI:ssc_pkg::MEAS_LO]),
    .cycle_tick(switch_cycle_tick),
    .probe_req(probe_request)
  );

  // channel 1 detect delays, rising and falling edge
  ssc_zcd_delay #(
    .STEP_CYC(ssc_pkg::DLY_STEP_CYC),
    .CNT_W(6)
  ) u_zcd (
    .clk(clk),
    .rst_n(rst_n),
    .zcd_in(zs2_r),
    .rise_steps(topo_r[ssc_pkg::DLY_HI:ssc_pkg::DLY_LO]),
    .fall_steps(shift_r[ssc_pkg::DLY_HI:ssc_pkg::DLY_LO]),
    .zcd_out(dly_out)
  );

  // delays apply only on channel 1 cycles; otherwise pass synced level
  always_comb begin
    zdl_nxt = chan1_active ? dly_out : zs2_r;
  end

  // registered so a channel change cannot glitch the detect output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zdl_r <= 1'b0;
    end else begin
      zdl_r <= zdl_nxt;
    end
  end

  assign zcd_delayed = zdl_r;
endmodule // ssc_config_regs

/* test/ssc_config_regs_properties.sv */
// port-level properties of the second stage configuration slice
`timescale 1ns/1ps
module ssc_config_regs_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [23:0] integrator,
  input wire logic [7:0] chan2_target_current,
  input wire logic switch_cycle_tick,
  input wire logic zero_cross_detect,
  input wire logic chan1_active,
  input wire logic [9:0] peak_threshold,
  input wire logic [8:0] chan1_target,
  input wire logic [8:0] chan2_target,
  input wire logic probe_request,
  input wire logic zcd_delayed,
  input wire logic tapped_buck,
  input wire logic [3:0] tap_ratio
);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // read data only in the cycle after a read strobe
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  AST_RSVD_ZERO: assert property (
    reg_rd && reg_addr == ssc_pkg::ADDR_PROBE |=> reg_rdata[2:0] == 3'h0)
    else $error("reserved probe bits not zero");
  AST_TAP_WR: assert property (
    reg_wr && reg_addr == ssc_pkg::ADDR_TOPO
    |-> ##2 tap_ratio == $past(reg_wdata[7:4], 2))
    else $error("tap ratio not taken from write");
  AST_TAP_MODE: assert property (
    tapped_buck == (tap_ratio >= 4'h2))
    else $error("tapped mode disagrees with ratio");
  AST_CH1_LOW: assert property (
    reg_wr && reg_addr == ssc_pkg::ADDR_CUR1
    |-> ##2 chan1_target[7:0] == $past(reg_wdata, 2))
    else $error("channel 1 low byte wrong");
  AST_CH1_MSB: assert property (
    reg_wr && reg_addr == ssc_pkg::ADDR_SHIFT
    |-> ##2 chan1_target[8] == $past(reg_wdata[0], 2))
    else $error("channel 1 top bit wrong");
  AST_CH2_MSB: assert property (
    reg_wr && reg_addr == ssc_pkg::ADDR_TOPO
    |-> ##2 chan2_target[8] == $past(reg_wdata[0], 2))
    else $error("channel 2 top bit wrong");
  AST_CH2_LOW: assert property (
    1'b1 |=> chan2_target[7:0] == $past(chan2_target_current))
    else $error("channel 2 low byte wrong");
  AST_PROBE_TICK: assert property (
    probe_request |-> $past(switch_cycle_tick))
    else $error("probe without a cycle tick");
  AST_PROBE_ONE: assert property (probe_request |=> !probe_request)
    else $error("probe request longer than a cycle");
  AST_ZCD_IDLE: assert property (
    !chan1_active |=> zcd_delayed == $past(zero_cross_detect, 3))
    else $error("detect path delayed outside channel 1");
  // main scenarios reached
  COV_PROBE: cover property (probe_request);
  COV_RSVD: cover property (reg_rd && reg_addr == ssc_pkg::ADDR_PROBE);
  COV_ZCD: cover property (chan1_active && $rose(zcd_delayed));
endmodule // ssc_config_regs_properties

bind ssc_config_regs ssc_config_regs_properties chk_u (.clk, .rst_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .integrator,
  .chan2_target_current, .switch_cycle_tick, .zero_cross_detect,
  .chan1_active, .peak_threshold, .chan1_target, .chan2_target,
  .probe_request, .zcd_delayed, .tapped_buck, .tap_ratio);

/* test/tb_ssc_config_regs.sv */
// self-checking bench for the second stage configuration slice
`timescale 1ns/1ps
module tb_ssc_config_regs;
  logic clk, rst_n, reg_wr, reg_rd, tick, zcd, c1a, preq, zdl, tb;
  logic [7:0] reg_addr, reg_wdata, rdata, cur2;
  logic [23:0] integ;
  logic [9:0] thr;
  logic [8:0] t1, t2;
  logic [3:0] tr;
  int err_count, num_checks, cyc, n, p;
  int m[4]; // register model
  ssc_config_regs dut_u (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata(rdata), .integrator(integ),
    .chan2_target_current(cur2), .switch_cycle_tick(tick),
    .zero_cross_detect(zcd), .chan1_active(c1a), .peak_threshold(thr),
    .chan1_target(t1), .chan2_target(t2), .probe_request(preq),
    .zcd_delayed(zdl), .tapped_buck(tb), .tap_ratio(tr));
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %0h got %0h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    m[a - 8'h27] = d;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("rdata", rdata, e);
  endtask
  // one switching cycle tick, then the probe output
  task automatic tk();
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    @(negedge clk);
    p = preq;
  endtask
  // edge on the detect pin, cycles until the output follows
  task automatic zl(input logic v, input int e);
    int q;
    q = 0;
    @(posedge clk);
    zcd <= v;
    do begin
      @(negedge clk);
      q++;
    end while (zdl !== v && q < 99);
    chk("zcd", q, e);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    {rst_n, reg_wr, reg_rd, tick, zcd, c1a} = 6'h00;
    {reg_addr, reg_wdata, cur2} = 24'h000000;
    integ = 24'h000000;
    void'($urandom(32'h303E));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and an unmapped index
    for (int i = 0; i < 4; i++) rd(8'(8'h27 + i), 8'h00);
    rd(8'h30, 8'h00);
    $display("test reset done");
    // random contents, every topology code
    for (int t = 0; t < 16; t++) begin
      wr(8'h27, 8'($urandom));
      wr(8'h28, 8'($urandom));
      wr(8'h29, 8'($urandom));
      wr(8'h2A, {4'(t), 4'($urandom)});
      cur2 <= 8'($urandom);
      repeat (2) @(negedge clk);
      chk("t1", t1, (m[1] % 2) * 256 + m[2]);
      chk("t2", t2, (m[3] % 2) * 256 + cur2);
      chk("tap", tr, t);
      chk("tb", tb, t >= 2);
      rd(8'h27, 8'(m[0] & 8'hF8));
      for (int i = 1; i < 4; i++) rd(8'(8'h27 + i), 8'(m[i]));
    end
    $display("test registers done");
    // threshold for every shift amount
    for (int s = 0; s < 16; s++) begin
      wr(8'h28, {4'(s), 4'h0});
      integ <= 24'($urandom);
      repeat (2) @(negedge clk);
      chk("thr", thr, (integ >> s) & 32'h3FF);
    end
    $display("test threshold done");
    // probe interval, two repeats each, longest count included
    for (int k = 0; k < 4; k++) begin
      int c;
      c = (k == 3) ? 15 : k;
      wr(8'h27, 8'(8'h80 | c << 3));
      repeat (2) begin
        n = 0;
        do begin
          n++;
          tk();
        end while (p == 0 && n < 300);
        chk("probe", n, 16 * c + 16);
      end
    end
    wr(8'h27, 8'h78);
    n = 0;
    repeat (64) begin
      tk();
      n += p;
    end
    chk("off", n, 0);
    $display("test probe done");
    // detect delays in channel 1 cycles, then the plain synced path
    @(posedge clk);
    c1a <= 1'b1;
    wr(8'h28, 8'h04);
    wr(8'h2A, 8'h06);
    zl(1'b1, 5 + 7 * 3);
    zl(1'b0, 5 + 7 * 2);
    @(posedge clk);
    c1a <= 1'b0;
    zl(1'b1, 4);
    $display("test detect done");
    tally_and_finish();
  end
endmodule // tb_ssc_config_regs
